// File: rtl/aof_pkg.sv
// aof_pkg: constants and types of the converter output control block
// assumes a 10 MHz sample clock and a 14-bit offset-binary core
`default_nettype none
package aof_pkg;
	// ********************************************************
	// widths and output codes
	// ********************************************************
	localparam int DATA_W  = 14;
	localparam int MSB     = DATA_W - 1;
	localparam int TIMER_W = 16;
	localparam int ADDR_W  = 4;
	localparam int BUS_W   = 32;
	localparam logic [DATA_W-1:0] CODE_ZERO  = 14'h0000;
	localparam logic [DATA_W-1:0] CODE_ONES  = 14'h3FFF;
	localparam logic [DATA_W-1:0] MID_OFFSET = 14'h2000;
	localparam logic [DATA_W-1:0] MID_TWOS   = 14'h0000;
	// ********************************************************
	// timing
	// ********************************************************
	localparam int CLK_HZ             = 10_000_000;
	localparam int NAP_RECOVERY_CLKS  = 100;
	localparam int SLEEP_RECOVERY_MS  = 2;
	localparam int SLEEP_RECOVERY_CYC =
		CLK_HZ / 1000 * SLEEP_RECOVERY_MS;
	localparam logic [1:0] CFG_SETTLE = 2'h2;
	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [ADDR_W-1:0] OFS_SLEEP_WAIT = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'hC;
	localparam int ST_TWOS  = 0;
	localparam int ST_STAB  = 1;
	localparam int ST_PWR   = 2;
	localparam int ST_VALID = 4;
	localparam int ST_OVF   = 5;
	localparam int ST_CFG   = 6;
	localparam int IRQ_W     = 3;
	localparam int IRQ_OVF   = 0;
	localparam int IRQ_DOWN  = 1;
	localparam int IRQ_READY = 2;
	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		AOF_MODE_GND   = 2'h0,
		AOF_MODE_THIRD = 2'h1,
		AOF_MODE_TWO3  = 2'h2,
		AOF_MODE_VDD   = 2'h3
	} aof_mode_t;
	typedef enum logic [1:0] {
		AOF_RUN   = 2'h0,
		AOF_NAP   = 2'h1,
		AOF_SLEEP = 2'h3,
		AOF_WAKE  = 2'h2
	} aof_pwr_t;
endpackage
`default_nettype wire

// File: rtl/aof_code_fmt.sv
// aof_code_fmt: clamps and codes one raw conversion result
// assumes raw codes arrive in offset binary from the core
`default_nettype none
module aof_code_fmt (
	// raw result
	input  wire logic [aof_pkg::DATA_W-1:0] raw_code,
	input  wire logic                       raw_over,
	input  wire logic                       raw_under,
	// configuration
	input  wire logic                       twos,
	// coded result
	output logic      [aof_pkg::DATA_W-1:0] code,
	output logic                            ovf
);
	import aof_pkg::*;
	logic [DATA_W-1:0] clamped;
	always_comb
	begin
		// over-range clamps to the full-scale code, under-range to the zero code
		if (raw_over)
			clamped = CODE_ONES;
		else if (raw_under)
			clamped = CODE_ZERO;
		else
			clamped = raw_code;
		// the two codings differ only in where midscale sits
		code = twos ? clamped ^ (MID_OFFSET ^ MID_TWOS) : clamped;
		ovf  = raw_over | raw_under;
	end
endmodule
`default_nettype wire

// File: rtl/aof_wake_timer.sv
// aof_wake_timer: down counter that times recovery after shutdown
// assumes load and abort come from logic on the same clock
`default_nettype none
module aof_wake_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// control
	input  wire logic         load,
	input  wire logic         abort,
	input  wire logic [W-1:0] load_val,
	// status
	output logic              busy,
	output logic              done
);
	import aof_pkg::*;
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
	} aof_tmr_t;
	localparam logic [W-1:0] ONE = W'(1);
	aof_tmr_t s;
	aof_tmr_t next_s;
	if (W < 2)
	begin : g_chk
		$error("aof_wake_timer: W must be at least 2");
	end
	always_comb
	begin
		next_s = s;
		if (abort)
			next_s.busy = 1'b0;
		else if (load)
		begin
			next_s.cnt  = load_val;
			next_s.busy = (load_val != '0);
		end
		else if (done)
			next_s.busy = 1'b0;
		else if (s.busy)
			next_s.cnt = s.cnt - ONE;
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			s <= '0;
		else if (ce)
			s <= next_s;
	end
	assign busy = s.busy;
	// last busy cycle; a load of n gives n busy cycles
	assign done = s.busy && (s.cnt == ONE);
endmodule
`default_nettype wire

// File: rtl/aof_adc_out.sv
// aof_adc_out: output coding, output enable and power modes of the
// converter; software sees status and interrupts over a plain port
// assumes pins are asynchronous, core results share ref_clk
//
// Strobed register access and the placing of the registers were left to the implementer.
`default_nettype none
module aof_adc_out #(
	parameter int SLEEP_CYC = aof_pkg::SLEEP_RECOVERY_CYC,
	parameter int NAP_CYC   = aof_pkg::NAP_RECOVERY_CLKS
) (
	// clock, reset, enable
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	// configuration and power pins
	input  wire logic [1:0]                 mode_level,
	input  wire logic                       power_down_request,
	input  wire logic                       out_enable_n,
	// conversion core
	input  wire logic [aof_pkg::DATA_W-1:0] raw_code,
	input  wire logic                       raw_over,
	input  wire logic                       raw_under,
	input  wire logic                       raw_valid,
	// sample outputs
	output logic      [aof_pkg::DATA_W-1:0] sample_word,
	output logic                            sample_word_oe,
	output logic                            range_overflow_flag,
	output logic                            range_overflow_oe,
	output logic                            sample_valid,
	// core control
	output logic                            duty_stab_on,
	output logic                            conv_active,
	output logic                            ref_power_on,
	// register port
	input  wire logic [aof_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [aof_pkg::BUS_W-1:0]  reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [aof_pkg::BUS_W-1:0]  reg_rdata,
	// interrupt
	output logic                            irq
);
	import aof_pkg::*;

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [1:0]         mode_s1;
		logic [1:0]         mode_s2;
		logic               pd_s1;
		logic               pd_s2;
		logic               oen_s1;
		logic               oen_s2;
		logic [1:0]         cfg_cnt;
		logic               cfg_done;
		logic               twos;
		logic               stab;
		aof_pwr_t           pwr;
		logic               slept;
		logic [DATA_W-1:0]  word;
		logic               ovf;
		logic               valid;
		logic [TIMER_W-1:0] sleep_wait;
		logic [IRQ_W-1:0]   irq_stat;
		logic [IRQ_W-1:0]   irq_mask;
		logic [BUS_W-1:0]   rdata;
	} aof_top_t;

	localparam logic [TIMER_W-1:0] SLEEP_INIT = TIMER_W'(SLEEP_CYC);
	localparam logic [TIMER_W-1:0] NAP_LEN    = TIMER_W'(NAP_CYC);
	localparam logic [TIMER_W-1:0] WAIT_MIN   = TIMER_W'(1);

	if (SLEEP_CYC < 1 || SLEEP_CYC >= 2 ** TIMER_W ||
		NAP_CYC < 1 || NAP_CYC >= 2 ** TIMER_W)
	begin : g_chk
		$error("aof_adc_out: recovery counts out of range");
	end

	aof_top_t           s;
	aof_top_t           next_s;
	logic [DATA_W-1:0]  fmt_code;
	logic               fmt_ovf;
	logic               tmr_load;
	logic               tmr_abort;
	logic [TIMER_W-1:0] tmr_val;
	logic               tmr_busy;
	logic               tmr_done;
	logic               take;
	logic               drive;
	logic [IRQ_W-1:0]   irq_ev;
	logic [IRQ_W-1:0]   irq_clr;

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic is_shut(input aof_pwr_t p);
		is_shut = (p == AOF_NAP) || (p == AOF_SLEEP);
	endfunction

	function automatic logic [BUS_W-1:0] rd_word(
		input aof_top_t            st,
		input logic [ADDR_W-1:0]   a
	);
		logic [BUS_W-1:0] w;
		w = '0;
		unique case (a)
			OFS_SLEEP_WAIT: w[TIMER_W-1:0] = st.sleep_wait;
			OFS_STATUS:
			begin
				w[ST_TWOS]         = st.twos;
				w[ST_STAB]         = st.stab;
				w[ST_PWR +: 2]     = st.pwr;
				w[ST_VALID]        = st.valid;
				w[ST_OVF]          = st.ovf;
				w[ST_CFG]          = st.cfg_done;
			end
			OFS_IRQ_STAT:   w[IRQ_W-1:0] = st.irq_stat;
			OFS_IRQ_MASK:   w[IRQ_W-1:0] = st.irq_mask;
			default:        w = '0;
		endcase
		rd_word = w;
	endfunction

	// ********************************************************
	// submodules
	// ********************************************************
	aof_code_fmt u_fmt (
		.raw_code  (raw_code),
		.raw_over  (raw_over),
		.raw_under (raw_under),
		.twos      (s.twos),
		.code      (fmt_code),
		.ovf       (fmt_ovf)
	);

	aof_wake_timer #(
		.W (TIMER_W)
	) u_tmr (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (tmr_load),
		.abort    (tmr_abort),
		.load_val (tmr_val),
		.busy     (tmr_busy),
		.done     (tmr_done)
	);

	// leaving shutdown starts the recovery timer; a slept reference
	// needs the long wait, a napping one the short wait
	assign tmr_load  = is_shut(s.pwr) && !s.pd_s2;
	assign tmr_val   = s.slept ? s.sleep_wait : NAP_LEN;
	assign tmr_abort = (s.pwr == AOF_WAKE) && s.pd_s2;
	// only the rising edge of ref_clk is used; no falling-edge logic
	assign take      = s.cfg_done && raw_valid &&
		((s.pwr == AOF_RUN) || (s.pwr == AOF_WAKE));
	assign irq_ev    = {
		(s.pwr == AOF_WAKE) && tmr_done,
		(s.pwr == AOF_RUN) && s.pd_s2,
		take && fmt_ovf
	};
	assign irq_clr   = (reg_wr && reg_addr == OFS_IRQ_STAT) ?
		reg_wdata[IRQ_W-1:0] : '0;

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		next_s = s;
		next_s.mode_s1 = mode_level;
		next_s.mode_s2 = s.mode_s1;
		next_s.pd_s1   = power_down_request;
		next_s.pd_s2   = s.pd_s1;
		next_s.oen_s1  = out_enable_n;
		next_s.oen_s2  = s.oen_s1;
		// format is taken once the synchroniser holds real pin levels
		if (!s.cfg_done)
		begin
			next_s.cfg_cnt = s.cfg_cnt + 2'h1;
			if (s.cfg_cnt == CFG_SETTLE)
			begin
				next_s.cfg_done = 1'b1;
				next_s.twos = (s.mode_s2 == AOF_MODE_TWO3) ||
					(s.mode_s2 == AOF_MODE_VDD);
				next_s.stab = (s.mode_s2 == AOF_MODE_THIRD) ||
					(s.mode_s2 == AOF_MODE_TWO3);
			end
		end
		unique case (s.pwr)
			AOF_RUN:
			begin
				if (s.pd_s2)
				begin
					next_s.pwr   = s.oen_s2 ? AOF_SLEEP : AOF_NAP;
					next_s.slept = s.oen_s2;
					next_s.valid = 1'b0;
				end
			end
			AOF_NAP:
			begin
				if (!s.pd_s2)
					next_s.pwr = AOF_WAKE;
				else if (s.oen_s2)
				begin
					next_s.pwr   = AOF_SLEEP;
					next_s.slept = 1'b1;
				end
			end
			AOF_SLEEP:
			begin
				// reference stays discharged: slept is kept
				if (!s.pd_s2)
					next_s.pwr = AOF_WAKE;
				else if (!s.oen_s2)
					next_s.pwr = AOF_NAP;
			end
			AOF_WAKE:
			begin
				if (s.pd_s2)
				begin
					next_s.pwr   = s.oen_s2 ? AOF_SLEEP : AOF_NAP;
					next_s.slept = s.slept | s.oen_s2;
				end
				else if (tmr_done)
				begin
					next_s.pwr   = AOF_RUN;
					next_s.slept = 1'b0;
				end
			end
		endcase
		// words made during recovery are driven but marked invalid
		if (take)
		begin
			next_s.word  = fmt_code;
			next_s.ovf   = fmt_ovf;
			next_s.valid = (s.pwr == AOF_RUN);
		end
		if (reg_wr && reg_addr == OFS_SLEEP_WAIT)
			next_s.sleep_wait = (reg_wdata[TIMER_W-1:0] == '0) ?
				WAIT_MIN : reg_wdata[TIMER_W-1:0];
		if (reg_wr && reg_addr == OFS_IRQ_MASK)
			next_s.irq_mask = reg_wdata[IRQ_W-1:0];
		// a new event beats a clear in the same cycle
		next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_ev;
		next_s.rdata = reg_rd ? rd_word(s, reg_addr) : '0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s            <= '0;
			s.pwr        <= AOF_RUN;
			s.sleep_wait <= SLEEP_INIT;
		end
		else if (ce)
			s <= next_s;
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign drive = s.cfg_done && !s.oen_s2 && !is_shut(s.pwr);
	assign sample_word         = s.word;
	assign range_overflow_flag = s.ovf;
	assign sample_word_oe      = drive;
	assign range_overflow_oe   = drive;
	assign sample_valid        = s.valid;
	assign duty_stab_on        = s.stab;
	assign conv_active         = !is_shut(s.pwr);
	assign ref_power_on        = (s.pwr != AOF_SLEEP) && !(s.slept &&
		s.pwr == AOF_NAP);
	assign reg_rdata           = s.rdata;
	assign irq                 = |(s.irq_stat & s.irq_mask);

	// ********************************************************
	// checks
	// ********************************************************
	logic [TIMER_W-1:0] ast_len;
	logic [TIMER_W-1:0] ast_cnt;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ast_len <= '0;
			ast_cnt <= '0;
		end
		else if (ce)
		begin
			if (tmr_load)
				ast_len <= tmr_val;
			ast_cnt <= (s.pwr == AOF_WAKE) ? ast_cnt + WAIT_MIN : '0;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_oen_high;
		(ce && s.oen_s2) [*2];
	endsequence
	sequence s_nap_exit;
		ce && s.pwr == AOF_NAP && !s.pd_s2 && !s.slept;
	endsequence

	AST_TWOS_CODE: assert property (
		ce && take && !raw_over && !raw_under |=>
		sample_word[MSB] == ($past(raw_code[MSB]) ^ s.twos))
		else $error("sample word coding wrong");
	AST_STAB_SEL: assert property (
		ce && !s.cfg_done && s.cfg_cnt == CFG_SETTLE |=>
		duty_stab_on == ($past(s.mode_s2) == AOF_MODE_THIRD ||
		$past(s.mode_s2) == AOF_MODE_TWO3))
		else $error("duty stabilizer selection wrong");
	AST_CLAMP: assert property (
		ce && take && raw_over |=> range_overflow_flag &&
		sample_word == (s.twos ? (CODE_ONES ^ MID_OFFSET) : CODE_ONES))
		else $error("positive clamp wrong");
	AST_OVF: assert property (
		ce && take |=> range_overflow_flag == $past(raw_over | raw_under))
		else $error("overflow flag wrong");
	AST_OE_OFF: assert property (
		s_oen_high |-> !sample_word_oe && !range_overflow_oe)
		else $error("outputs driven while disabled");
	AST_RUN_DRIVE: assert property (
		s.cfg_done && s.pwr == AOF_RUN && !s.oen_s2 |-> sample_word_oe)
		else $error("normal mode not driving");
	AST_SLEEP: assert property (
		ce && s.pwr == AOF_RUN && s.pd_s2 && s.oen_s2 |=>
		s.pwr == AOF_SLEEP && !ref_power_on)
		else $error("sleep not entered");
	AST_NAP: assert property (
		ce && s.pwr == AOF_RUN && s.pd_s2 && !s.oen_s2 |=>
		s.pwr == AOF_NAP && ref_power_on && !conv_active)
		else $error("nap not entered");
	AST_NAP_LEN: assert property (
		s_nap_exit |=> ast_len == NAP_LEN)
		else $error("nap recovery length wrong");
	AST_WAKE_END: assert property (
		ce && s.pwr == AOF_WAKE && tmr_done && !s.pd_s2 |->
		ast_cnt == ast_len - WAIT_MIN ##1 s.pwr == AOF_RUN)
		else $error("recovery time wrong");
	AST_HIZ: assert property (
		is_shut(s.pwr) |-> !sample_word_oe && !range_overflow_oe)
		else $error("outputs driven in shutdown");
	AST_CFG_STATIC: assert property (
		s.cfg_done |=> $stable(s.twos) && $stable(s.stab))
		else $error("format changed in operation");
	AST_IRQ_SET_WINS: assert property (
		ce && irq_ev[IRQ_OVF] && irq_clr[IRQ_OVF] |=>
		s.irq_stat[IRQ_OVF])
		else $error("overflow event lost on clear");
endmodule
`default_nettype wire

// File: verif/aof_capture_model.sv
// aof_capture_model: capturing logic on the far side of the sample bus
// assumes it shares ref_clk with the converter and samples rising edges
`default_nettype none
module aof_capture_model (
	// clock
	input  wire logic                       ref_clk,
	// sample bus from the converter
	input  wire logic [aof_pkg::DATA_W-1:0] sample_word,
	input  wire logic                       sample_word_oe,
	input  wire logic                       range_overflow_flag,
	input  wire logic                       range_overflow_oe,
	input  wire logic                       sample_valid,
	// captured result
	output logic      [aof_pkg::DATA_W-1:0] cap_word,
	output logic                            cap_ovf
);
	timeunit 1ns;
	timeprecision 1ns;
	import aof_pkg::*;
	logic [DATA_W-1:0] bus;
	logic [DATA_W-1:0] last_bus;
	logic              ovf_line;
	logic              last_ovf;
	// a floating line toggles every cycle between the inverse of the old word and the old word
	assign bus      = sample_word_oe ? sample_word : ~last_bus;
	assign ovf_line = range_overflow_oe ? range_overflow_flag : ~last_ovf;
	initial
	begin
		last_bus = '0;
		last_ovf = 1'b0;
		cap_word = '0;
		cap_ovf  = 1'b0;
	end
	always @(posedge ref_clk)
	begin
		last_bus <= bus;
		last_ovf <= ovf_line;
		// words of the recovery span are dropped
		if (sample_word_oe && sample_valid)
		begin
			cap_word <= bus;
			cap_ovf  <= ovf_line;
		end
	end
endmodule
`default_nettype wire

// File: verif/adc_output_format_power_ctrl_tb.sv
// testbench of the converter output control block
// assumes the capture model sits on the sample bus, one 10 MHz clock
`default_nettype none
module adc_output_format_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import aof_pkg::*;
	// short sleep recovery keeps the run brief
	localparam int SLEEP_P = 20;
	logic              ref_clk;
	logic              rst_n;
	logic              ce;
	logic [1:0]        mode_level;
	logic              power_down_request;
	logic              out_enable_n;
	logic [DATA_W-1:0] raw_code;
	logic              raw_over;
	logic              raw_under;
	logic              raw_valid;
	logic [DATA_W-1:0] sample_word;
	logic              sample_word_oe;
	logic              range_overflow_flag;
	logic              range_overflow_oe;
	logic              sample_valid;
	logic              duty_stab_on;
	logic              conv_active;
	logic              ref_power_on;
	logic [ADDR_W-1:0] reg_addr;
	logic [BUS_W-1:0]  reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [BUS_W-1:0]  reg_rdata;
	logic              irq;
	logic [DATA_W-1:0] cap_word;
	logic              cap_ovf;
	logic [DATA_W-1:0] x;
	logic [BUS_W-1:0]  d;
	logic              tw;
	logic              st;
	int                miscompares;
	int                comparisons;
	aof_adc_out #(.SLEEP_CYC(SLEEP_P), .NAP_CYC(NAP_RECOVERY_CLKS)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .mode_level(mode_level),
		.power_down_request(power_down_request),
		.out_enable_n(out_enable_n), .raw_code(raw_code),
		.raw_over(raw_over), .raw_under(raw_under), .raw_valid(raw_valid),
		.sample_word(sample_word), .sample_word_oe(sample_word_oe),
		.range_overflow_flag(range_overflow_flag),
		.range_overflow_oe(range_overflow_oe),
		.sample_valid(sample_valid), .duty_stab_on(duty_stab_on),
		.conv_active(conv_active), .ref_power_on(ref_power_on),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	aof_capture_model partner (
		.ref_clk(ref_clk), .sample_word(sample_word),
		.sample_word_oe(sample_word_oe),
		.range_overflow_flag(range_overflow_flag),
		.range_overflow_oe(range_overflow_oe),
		.sample_valid(sample_valid), .cap_word(cap_word),
		.cap_ovf(cap_ovf));
	// ********************************************************
	// tasks
	// ********************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic send(input logic [13:0] c, input logic o, input logic u);
		@(posedge ref_clk);
		raw_code  <= c;
		raw_over  <= o;
		raw_under <= u;
		raw_valid <= 1'b1;
		@(posedge ref_clk);
		raw_valid <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic wait_valid(input int n);
		int i;
		i = 0;
		while (sample_valid !== 1'b1 && i < n)
		begin
			@(negedge ref_clk);
			i++;
		end
		check(32'(sample_valid), 32'h1);
	endtask
	// ********************************************************
	// clock and watchdog
	// ********************************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		#300000;
		miscompares++;
		results();
	end
	// ********************************************************
	// tests
	// ********************************************************
	initial
	begin
		miscompares = 0;
		comparisons = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		mode_level = 2'h0;
		power_down_request = 1'b0;
		out_enable_n = 1'b0;
		raw_code = '0;
		raw_over = 1'b0;
		raw_under = 1'b0;
		raw_valid = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		for (int m = 0; m < 4; m++)
		begin
			@(posedge ref_clk);
			mode_level <= 2'(m);
			rst_n <= 1'b0;
			cyc(2);
			rst_n <= 1'b1;
			cyc(6);
			tw = (m >= 2);
			st = (m == 1) || (m == 2);
			x = tw ? 14'h2000 : 14'h0000;
			@(negedge ref_clk);
			check(32'(duty_stab_on), 32'(st));
			check(32'(sample_word_oe), 32'h1);
			rd(OFS_STATUS);
			check(d & 32'h43, 32'({1'b1, 4'h0, st, tw}));
			send(14'h2000, 1'b0, 1'b0);
			check(32'(sample_word), 32'(tw ? MID_TWOS : MID_OFFSET));
			send(14'h1234, 1'b1, 1'b0);
			check(32'({range_overflow_flag, sample_word}),
				32'({1'b1, 14'h3FFF ^ x}));
			send(14'h1234, 1'b0, 1'b1);
			check(32'({range_overflow_flag, sample_word}),
				32'({1'b1, x}));
			send(14'h0001, 1'b0, 1'b0);
			check(32'({range_overflow_flag, sample_word}),
				32'({1'b0, 14'h0001 ^ x}));
			@(posedge ref_clk);
			mode_level <= ~2'(m);
			cyc(5);
			check(32'({cap_ovf, cap_word}),
				32'({1'b0, 14'h0001 ^ x}));
			rd(OFS_STATUS);
			check(d & 32'h3, 32'({st, tw}));
		end
		@(posedge ref_clk);
		out_enable_n <= 1'b1;
		cyc(4);
		@(negedge ref_clk);
		check(32'({sample_word_oe, range_overflow_oe}), 32'h0);
		@(posedge ref_clk);
		out_enable_n <= 1'b0;
		cyc(4);
		@(negedge ref_clk);
		check(32'({sample_word_oe, range_overflow_oe}), 32'h3);
		rd(OFS_IRQ_MASK);
		check(d, 32'h0);
		rd(OFS_SLEEP_WAIT);
		check(d, 32'(SLEEP_P));
		rd(4'h2);
		check(d, 32'h0);
		check(32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'h1);
		@(negedge ref_clk);
		check(32'(irq), 32'h1);
		// overflow word and its clear in one cycle: the event must stay
		@(posedge ref_clk);
		raw_over  <= 1'b1;
		raw_valid <= 1'b1;
		reg_addr  <= OFS_IRQ_STAT;
		reg_wdata <= 32'h1;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		raw_over  <= 1'b0;
		raw_valid <= 1'b0;
		reg_wr    <= 1'b0;
		rd(OFS_IRQ_STAT);
		check(d & 32'h1, 32'h1);
		wr(OFS_IRQ_STAT, 32'h7);
		wr(OFS_IRQ_MASK, 32'h6);
		rd(OFS_IRQ_STAT);
		check(d, 32'h0);
		check(32'(irq), 32'h0);
		// frozen clock enable: a result offered now is not taken
		@(posedge ref_clk);
		ce <= 1'b0;
		send(14'h0AAA, 1'b0, 1'b0);
		check(32'({range_overflow_flag, sample_word}),
			32'({1'b1, 14'h3FFF ^ 14'h2000}));
		@(posedge ref_clk);
		ce <= 1'b1;
		// nap: reference stays up, short recovery
		@(posedge ref_clk);
		raw_code  <= 14'h0100;
		raw_valid <= 1'b1;
		power_down_request <= 1'b1;
		cyc(5);
		@(negedge ref_clk);
		check(32'({conv_active, ref_power_on}), 32'h1);
		check(32'({sample_word_oe, range_overflow_oe}), 32'h0);
		check(32'(irq), 32'h1);
		@(posedge ref_clk);
		power_down_request <= 1'b0;
		cyc(95);
		@(negedge ref_clk);
		check(32'(sample_valid), 32'h0);
		wait_valid(20);
		rd(OFS_IRQ_STAT);
		check(d, 32'h6);
		// sleep, then nap from sleep keeps the sleep_wait recovery of 30 cycles, not the nap one
		wr(OFS_SLEEP_WAIT, 32'd30);
		wr(OFS_IRQ_STAT, 32'h7);
		out_enable_n <= 1'b1;
		power_down_request <= 1'b1;
		cyc(5);
		@(negedge ref_clk);
		check(32'({conv_active, ref_power_on}), 32'h0);
		@(posedge ref_clk);
		out_enable_n <= 1'b0;
		cyc(5);
		@(negedge ref_clk);
		check(32'({sample_word_oe, range_overflow_oe}), 32'h0);
		check(32'(ref_power_on), 32'h0);
		// recovery words carry a new code that capture must not keep
		@(posedge ref_clk);
		power_down_request <= 1'b0;
		raw_code <= 14'h0555;
		cyc(25);
		@(negedge ref_clk);
		check(32'(sample_valid), 32'h0);
		check(32'(cap_word), 32'(14'h0100 ^ 14'h2000));
		wait_valid(20);
		cyc(1);
		@(negedge ref_clk);
		check(32'(cap_word), 32'(14'h0555 ^ 14'h2000));
		// nap, then output enable high turns it into sleep
		@(posedge ref_clk);
		power_down_request <= 1'b1;
		cyc(5);
		@(negedge ref_clk);
		check(32'({conv_active, ref_power_on}), 32'h1);
		@(posedge ref_clk);
		out_enable_n <= 1'b1;
		cyc(5);
		@(negedge ref_clk);
		check(32'({conv_active, ref_power_on}), 32'h0);
		results();
	end
endmodule
`default_nettype wire
